// *** dv/mac_load_checker.sv ***
`timescale 1ns/1ps
module mac_load_checker
    import mac_load_pkg::*;
#(
    parameter int GR_IDX_W = 4
) (
    input wire logic                hclk, hresetn, op_valid, op_ready, op_done, gr_wr_en,
    input wire logic                exc_valid, mem_req_valid, mem_req_ready,
    input wire logic                mem_rsp_valid, mem_rsp_err,
    input wire logic [1:0]          op_half, exc_cause,
    input wire logic [2:0]          op_code,
    input wire logic [GR_IDX_W-1:0] op_gr_idx, gr_wr_idx,
    input wire logic [31:0]         op_gr_s, op_gr_t, gr_wr_data, xlat_vaddr, mem_req_addr,
    input wire logic [ACC_W-1:0]    acc_value
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Expected results worked out from the operands at the accept edge.
    logic signed [15:0] h1, h2;
    logic signed [39:0] prod;
    logic [39:0]        acc_sub;
    logic [31:0]        mul_lo, ld_va;
    assign h1 = op_half[0] ? op_gr_s[31:16] : op_gr_s[15:0];
    assign h2 = op_half[1] ? op_gr_t[31:16] : op_gr_t[15:0];
    assign prod = h1 * h2;
    assign acc_sub = acc_value - prod;
    assign mul_lo = op_gr_s * op_gr_t;
    assign ld_va = op_code[0] ? op_gr_s + LOAD_STEP : op_gr_s - LOAD_STEP;
    sequence take(logic [2:0] c);
        op_valid && op_ready && op_code == c;
    endsequence
    sequence ld_take;
        op_valid && op_ready && op_code[2:1] == 2'h0 && op_gr_s[1:0] == 2'h0;
    endsequence
    sequence rsp_in(logic e);
        mem_rsp_valid && mem_rsp_err == e && !op_ready;
    endsequence
    gg_subtract_a: assert property (take(OP_SUB_GG) |=> op_done && acc_value == $past(acc_sub))
        else $error("general pair subtract gave a wrong accumulator");
    multiply_low_word_result_a: assert property (take(OP_MULTIPLY_LOW) |=> gr_wr_en
        && gr_wr_data == $past(mul_lo) && gr_wr_idx == $past(op_gr_idx))
        else $error("low multiply result wrong");
    load_addr_a: assert property (ld_take |=> !op_ready && xlat_vaddr == $past(ld_va))
        else $error("load address wrong");
    req_hold_a: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid
        && $stable(mem_req_addr)) else $error("memory request dropped or changed");
    load_ok_a: assert property (rsp_in(1'b0) |=> op_done && gr_wr_en)
        else $error("good load did not complete");
    load_fault_a: assert property (rsp_in(1'b1) |=> exc_valid && !op_done
        && !gr_wr_en && exc_cause == CAUSE_LOAD_FAULT) else $error("failed load not trapped");
    done_pulse_a: assert property (op_done && !op_valid |=> !op_done)
        else $error("done held longer than one cycle");
    exc_pulse_a: assert property (exc_valid && !op_valid |=> !exc_valid)
        else $error("trap held longer than one cycle");
endmodule

// *** dv/mac_load_datapath_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, v); end end
module mac_load_datapath_tb_top
    import mac_load_pkg::*;
;
    localparam logic [31:0] FAULT_VA = 32'h0000_0300;
    localparam logic [31:0] ERR_PA   = 32'h0000_0200;
    localparam logic [31:0] FLIP     = 32'h0001_0000;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, op_valid = 1'b0, slow = 1'b0;
    logic        op_x = 1'b0, op_y = 1'b0;
    logic [1:0]  htrans = 2'h0, op_half = 2'h0, op_w = 2'h0;
    logic [2:0]  hsize = 3'h2, op_code = 3'h0;
    logic [3:0]  op_gr_idx = 4'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, op_gr_s = 32'h0, op_gr_t = 32'h0, rd, wrd;
    logic [39:0] acc_exp = 40'h0;
    logic        dn, ex;
    int          err_count = 0, samples_checked = 0;
    wire logic   hsel = 1'b1;
    wire logic   hready, hreadyout, hresp, irq, op_ready, op_done, gr_wr_en, exc_valid;
    wire logic   mem_req_valid, mem_req_ready, xlat_fault, mem_rsp_valid, mem_rsp_err;
    wire logic [1:0]  exc_cause;
    wire logic [3:0]  gr_wr_idx;
    wire logic [31:0] hrdata, gr_wr_data, xlat_vaddr, xlat_paddr, mem_req_addr;
    wire logic [31:0] mem_rsp_data, exc_addr, last_addr;
    wire logic [39:0] acc_value;
    assign hready = hreadyout;
    mac_load_datapath dut_u (.*);
    mem_partner #(.FAULT_VA(FAULT_VA), .ERR_PA(ERR_PA), .FLIP(FLIP)) mem_u (.*);
    always #12.5 hclk = ~hclk;
    // One single word transfer; read data lands in rd.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Issue one decoder operation and wait for done or a trap.
    task automatic op(input logic [2:0] c, input logic [1:0] h, input logic [31:0] s, t);
        op_code <= c;
        op_half <= h;
        op_gr_s <= s;
        op_gr_t <= t;
        op_valid <= 1'b1;
        do @(posedge hclk); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        dn = 1'b0;
        ex = 1'b0;
        for (int i = 0; i < 30 && !(dn || ex); i++) begin
            @(posedge hclk);
            dn = op_done === 1'b1;
            ex = exc_valid === 1'b1;
            wrd = gr_wr_data;
        end
    endtask
    function automatic logic [39:0] hp(input logic [31:0] a, b, input logic [1:0] h);
        logic signed [15:0] p, q;
        logic signed [39:0] r;
        p = h[0] ? a[31:16] : a[15:0];
        q = h[1] ? b[31:16] : b[15:0];
        r = p * q;
        return r;
    endfunction
    // Subtract forms from zero, so the accumulator wraps below zero.
    task automatic t_sub();
        for (int h = 0; h < 4; h++) begin
            op(OP_SUB_GG, 2'(h), 32'h8001_7FFF, 32'hFFFE_8000);
            acc_exp = acc_exp - hp(32'h8001_7FFF, 32'hFFFE_8000, 2'(h));
            `CHK("acc gg", acc_exp, acc_value)
        end
        ahb(1'b1, OFF_MR0 + 8'h0C, 32'hC000_0007);
        ahb(1'b1, OFF_MR0 + 8'h04, 32'h0009_FFF7);
        op_x <= 1'b1;
        op_y <= 1'b1;
        op(OP_SUB_GM, 2'h3, 32'h0005_1234, 32'h0);
        acc_exp = acc_exp - hp(32'h0005_1234, 32'hC000_0007, 2'h3);
        `CHK("acc gm", acc_exp, acc_value)
        op(OP_SUB_MG, 2'h0, 32'h0, 32'h0002_8001);
        acc_exp = acc_exp - hp(32'h0009_FFF7, 32'h0002_8001, 2'h0);
        `CHK("acc mg", acc_exp, acc_value)
        op_gr_idx <= 4'h5;
        op(OP_MULTIPLY_LOW, 2'h0, 32'hFFFF_FFFD, 32'h0001_0003);
        `CHK("multiply_low_word", 32'hFFFF_FFFD * 32'h0001_0003, wrd)
    endtask
    // Loads: destination equal to a source, then misaligned through translation.
    task automatic t_load();
        slow <= 1'b1;
        ahb(1'b1, OFF_MR0 + 8'h04, 32'h7FFF_8000);
        ahb(1'b1, OFF_MR0 + 8'h08, 32'h0003_FFFE);
        op_y <= 1'b0;
        op_w <= 2'h2;
        op(OP_MAC_LOAD_PREDEC, 2'h1, 32'h0000_1000, 32'h0);
        acc_exp = acc_exp + hp(32'h7FFF_8000, 32'h0003_FFFE, 2'h1);
        `CHK("acc ld", acc_exp, acc_value)
        `CHK("base dec", 32'h0000_0FFC, wrd)
        `CHK("phys", 32'h0000_0FFC, last_addr)
        ahb(1'b0, OFF_MR0 + 8'h08, 32'h0);
        `CHK("mreg2", ~32'h0000_0FFC, rd)
        ahb(1'b1, OFF_CTRL, 32'h2);
        ahb(1'b1, OFF_MR0, 32'hFFFF_0010);
        ahb(1'b1, OFF_MR0 + 8'h0C, 32'h0001_0123);
        op_x <= 1'b0;
        op_y <= 1'b1;
        op_w <= 2'h0;
        op(OP_MAC_LOAD_PREINC, 2'h3, 32'h0000_2002, 32'h0);
        acc_exp = acc_exp + hp(32'hFFFF_0010, 32'h0001_0123, 2'h3);
        `CHK("acc inc", acc_exp, acc_value)
        `CHK("base inc", 32'h0000_2006, wrd)
        `CHK("phys xl", 32'h0000_2004 ^ FLIP, last_addr)
        ahb(1'b0, OFF_MR0, 32'h0);
        `CHK("mreg0", ~(32'h0000_2004 ^ FLIP), rd)
    endtask
    // Trapped misalignment, memory error with interrupt, translation fault.
    task automatic t_fault();
        ahb(1'b1, OFF_CTRL, 32'h1);
        op(OP_MAC_LOAD_PREDEC, 2'h0, 32'h0000_3001, 32'h0);
        `CHK("trap", CAUSE_MISALIGN, ex ? exc_cause : 2'h0)
        `CHK("masked irq", 1'b0, irq)
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b1, OFF_MASK, 32'h2);
        op(OP_MAC_LOAD_PREINC, 2'h0, ERR_PA - 32'h4, 32'h0);
        `CHK("mem err", CAUSE_LOAD_FAULT, ex ? exc_cause : 2'h0)
        `CHK("err addr", ERR_PA, exc_addr)
        `CHK("acc kept", acc_exp, acc_value)
        ahb(1'b0, OFF_MR0, 32'h0);
        `CHK("mreg kept", ~(32'h0000_2004 ^ FLIP), rd)
        `CHK("irq", 1'b1, irq)
        ahb(1'b1, OFF_STATUS, 32'h2);
        @(posedge hclk);
        `CHK("irq clr", 1'b0, irq)
        ahb(1'b1, OFF_CTRL, 32'h2);
        op(OP_MAC_LOAD_PREDEC, 2'h0, FAULT_VA + 32'h4, 32'h0);
        `CHK("xlat flt", FAULT_VA, ex ? exc_addr : 32'h0)
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence after a three cycle reset.
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_sub();
        t_load();
        t_fault();
        test_done();
    end
    // The tests need under a thousand cycles; a hang ends the run here.
    initial begin
        #(25 * 5000);
        err_count++;
        test_done();
    end
endmodule
bind mac_load_datapath mac_load_checker #(.GR_IDX_W(GR_IDX_W)) chk_u (.*);

// *** dv/mem_partner.sv ***
`timescale 1ns/1ps
module mem_partner #(
    parameter logic [31:0] FAULT_VA = 32'h0000_0300,
    parameter logic [31:0] ERR_PA   = 32'h0000_0200,
    parameter logic [31:0] FLIP     = 32'h0001_0000
) (
    input  wire logic        hclk, hresetn, slow, mem_req_valid,
    input  wire logic [31:0] xlat_vaddr, mem_req_addr,
    output logic             xlat_fault, mem_req_ready, mem_rsp_valid, mem_rsp_err,
    output logic [31:0]      xlat_paddr, mem_rsp_data, last_addr
);
    logic        gap_r;
    logic [31:0] noise_r;
    assign xlat_paddr = xlat_vaddr ^ FLIP;
    assign xlat_fault = xlat_vaddr == FAULT_VA;
    // A slow memory takes a request only every other cycle.
    assign mem_req_ready = mem_req_valid && !mem_rsp_valid && (!slow || gap_r);
    // Outside an answer the data lines move, so stale data can never pass.
    assign mem_rsp_data = mem_rsp_valid ? ~last_addr : noise_r;
    assign mem_rsp_err = mem_rsp_valid && last_addr == ERR_PA;
    // Answer one cycle after the request is taken.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_r <= 1'b0;
            mem_rsp_valid <= 1'b0;
            last_addr <= 32'h0;
            noise_r <= 32'h5A5A_C3C3;
        end else begin
            gap_r <= !gap_r;
            noise_r <= {noise_r[30:0], noise_r[31]} ^ 32'h0000_0001;
            mem_rsp_valid <= mem_req_ready;
            if (mem_req_ready) begin
                last_addr <= mem_req_addr;
            end
        end
    end
endmodule

// *** hdl/mac_load_datapath.sv ***
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mac_load_datapath
    import mac_load_pkg::*;
#(
    parameter int GR_IDX_W = 4
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    output logic                     irq,
    input  wire logic                op_valid,
    output logic                     op_ready,
    input  wire logic [2:0]          op_code,
    input  wire logic [1:0]          op_half,
    input  wire logic                op_x,
    input  wire logic                op_y,
    input  wire logic [1:0]          op_w,
    input  wire logic [GR_IDX_W-1:0] op_gr_idx,
    input  wire logic [31:0]         op_gr_s,
    input  wire logic [31:0]         op_gr_t,
    output logic                     op_done,
    output logic                     gr_wr_en,
    output logic [GR_IDX_W-1:0]      gr_wr_idx,
    output logic [31:0]              gr_wr_data,
    output logic [31:0]              xlat_vaddr,
    input  wire logic [31:0]         xlat_paddr,
    input  wire logic                xlat_fault,
    output logic                     mem_req_valid,
    input  wire logic                mem_req_ready,
    output logic [31:0]              mem_req_addr,
    input  wire logic                mem_rsp_valid,
    input  wire logic [31:0]         mem_rsp_data,
    input  wire logic                mem_rsp_err,
    output logic                     exc_valid,
    output logic [1:0]               exc_cause,
    output logic [31:0]              exc_addr,
    output logic [ACC_W-1:0]         acc_value
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (GR_IDX_W < 1 || GR_IDX_W > 8) begin : g_bad_width
        $error("GR_IDX_W must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_e              state_r;
    state_e              state_nxt;
    logic [WORD_W-1:0]   mr_r [MR_NUM];
    logic [ACC_W-1:0]    acc_r;
    logic [ACC_W-1:0]    acc_nxt;
    logic [CTRL_W-1:0]   ctrl_r;
    logic [EV_W-1:0]     sts_r;
    logic [EV_W-1:0]     sts_nxt;
    logic [EV_W-1:0]     mask_r;
    logic [WORD_W-1:0]   fault_addr_r;
    logic [HALF_W-1:0]   m1_r;
    logic [HALF_W-1:0]   m2_r;
    logic [1:0]          w_r;
    logic [GR_IDX_W-1:0] idx_r;
    logic [WORD_W-1:0]   vaddr_r;
    logic                done_r;
    logic                gr_wr_en_r;
    logic [GR_IDX_W-1:0] gr_wr_idx_r;
    logic [WORD_W-1:0]   gr_wr_data_r;
    logic                exc_valid_r;
    logic [1:0]          exc_cause_r;
    logic                wr_pend_r;
    logic [7:0]          wr_addr_r;
    logic [31:0]         hrdata_r;

    // ------------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------------
    // General register sources go to the first operand for the two forms
    // that start with a general register, and likewise for the second.
    wire                 is_load   = (op_code == OP_MAC_LOAD_PREDEC) ||
                                     (op_code == OP_MAC_LOAD_PREINC);
    wire                 is_sub    = (op_code == OP_SUB_GG) || (op_code == OP_SUB_GM) ||
                                     (op_code == OP_SUB_MG);
    wire                 is_multiply_low_word   = (op_code == OP_MULTIPLY_LOW);
    wire                 op1_gen   = (op_code == OP_SUB_GG) || (op_code == OP_SUB_GM);
    wire                 op2_gen   = (op_code == OP_SUB_GG) || (op_code == OP_SUB_MG);
    wire [1:0]           mr1_idx   = {1'b0, op_x};
    wire [1:0]           mr2_idx   = {1'b1, op_y};
    wire [WORD_W-1:0]    op1_word  = op1_gen ? op_gr_s : mr_r[mr1_idx];
    wire [WORD_W-1:0]    op2_word  = op2_gen ? op_gr_t : mr_r[mr2_idx];
    wire [HALF_W-1:0]    m1        = op_half[0] ? op1_word[31:16] : op1_word[15:0];
    wire [HALF_W-1:0]    m2        = op_half[1] ? op2_word[31:16] : op2_word[15:0];

    // ------------------------------------------------------------------
    // Multipliers
    // ------------------------------------------------------------------
    // signed half product, sign-extended.
    wire signed [31:0]   prod_now  = $signed(m1) * $signed(m2);
    wire [ACC_W-1:0]     prod_now_x = {{(ACC_W-32){prod_now[31]}}, prod_now};
    // The loading forms accumulate from operands captured at issue, so a
    // destination that aliases a source cannot feed the fresh word back.
    wire signed [31:0]   prod_cap  = $signed(m1_r) * $signed(m2_r);
    wire [ACC_W-1:0]     prod_cap_x = {{(ACC_W-32){prod_cap[31]}}, prod_cap};
    wire [WORD_W-1:0]    multiply_low_word_low  = op_gr_s * op_gr_t;

    // ------------------------------------------------------------------
    // Load address generation
    // ------------------------------------------------------------------
    // base minus or plus four.
    wire [WORD_W-1:0]    vaddr_calc = (op_code == OP_MAC_LOAD_PREDEC) ? op_gr_s - LOAD_STEP
                                                                      : op_gr_s + LOAD_STEP;
    wire                 trap_en    = ctrl_r[CTRL_TRAP_BIT];
    wire                 xlat_en    = ctrl_r[CTRL_XLAT_BIT];
    wire                 misaligned = (vaddr_calc[1:0] != 2'h0);
    // low bits ignored when not trapping.
    wire [WORD_W-1:0]    vaddr_eff  = trap_en ? vaddr_r : {vaddr_r[31:2], 2'h0};
    wire [WORD_W-1:0]    phys_addr  = xlat_en ? xlat_paddr : vaddr_eff;

    // ------------------------------------------------------------------
    // Sequencing terms
    // ------------------------------------------------------------------
    wire accept       = op_valid && (state_r == ST_IDLE);
    wire ev_misalign  = accept && is_load && trap_en && misaligned;
    wire xlat_err     = (state_r == ST_REQ) && xlat_en && xlat_fault;
    wire mem_err      = (state_r == ST_WAIT) && mem_rsp_valid && mem_rsp_err;
    wire ev_fault     = xlat_err || mem_err;
    wire commit       = (state_r == ST_WAIT) && mem_rsp_valid && !mem_rsp_err;
    wire ev_done      = (accept && (is_sub || is_multiply_low_word)) || commit;
    wire [EV_W-1:0] ev_set = {ev_misalign, ev_fault, ev_done};

    // Next state of the load sequence.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept && is_load && !ev_misalign) begin
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ: begin
                if (xlat_err) begin
                    state_nxt = ST_IDLE;
                end else if (mem_req_ready) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_rsp_valid) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire bus_act    = hsel && hready && htrans[1];
    wire bus_word   = (hsize == 3'h2);
    wire wr_ctrl    = wr_pend_r && (wr_addr_r == OFF_CTRL);
    wire wr_status  = wr_pend_r && (wr_addr_r == OFF_STATUS);
    wire wr_mask    = wr_pend_r && (wr_addr_r == OFF_MASK);
    wire wr_acc_lo  = wr_pend_r && (wr_addr_r == OFF_ACC_LO);
    wire wr_acc_hi  = wr_pend_r && (wr_addr_r == OFF_ACC_HI);
    wire [7:0] mr_off  = haddr[7:0] - OFF_MR0;
    wire [7:0] wmr_off = wr_addr_r - OFF_MR0;
    wire rd_is_mr   = (haddr[7:0] >= OFF_MR0) && (mr_off < 8'(MR_NUM * 4));
    wire wr_is_mr   = wr_pend_r && (wr_addr_r >= OFF_MR0) && (wmr_off < 8'(MR_NUM * 4));
    wire [31:0] rd_mux =
        (haddr[7:0] == OFF_CTRL)       ? {30'h0, ctrl_r} :
        (haddr[7:0] == OFF_STATUS)     ? {29'h0, sts_r} :
        (haddr[7:0] == OFF_MASK)       ? {29'h0, mask_r} :
        (haddr[7:0] == OFF_FAULT_ADDR) ? fault_addr_r :
        (haddr[7:0] == OFF_ACC_LO)     ? acc_r[31:0] :
        (haddr[7:0] == OFF_ACC_HI)     ? {24'h0, acc_r[39:32]} :
        rd_is_mr                       ? mr_r[mr_off[3:2]] : 32'h0;

    // Address phase is latched; write data lands one cycle later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            wr_pend_r <= bus_act && hwrite && bus_word && (haddr[31:8] == 24'h00_0000);
            wr_addr_r <= haddr[7:0];
            if (bus_act && !hwrite) begin
                hrdata_r <= (haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, status and mask
    // ------------------------------------------------------------------
    // A new event beats a write-one-to-clear in the same cycle.
    always_comb begin
        sts_nxt = sts_r;
        if (wr_status) begin
            sts_nxt = sts_r & ~hwdata[EV_W-1:0];
        end
        sts_nxt = sts_nxt | ev_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RESET;
            mask_r <= MASK_RESET;
            sts_r  <= '0;
        end else begin
            sts_r <= sts_nxt;
            if (wr_ctrl) begin
                ctrl_r <= hwdata[CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_r <= hwdata[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    // The datapath wins over a bus write in the same cycle; software is
    // expected to load the accumulator only while the unit is idle.
    always_comb begin
        acc_nxt = acc_r;
        if (accept && is_sub) begin
            acc_nxt = acc_r - prod_now_x;
        end else if (commit) begin
            acc_nxt = acc_r + prod_cap_x;
        end else if (wr_acc_lo) begin
            acc_nxt = {acc_r[39:32], hwdata};
        end else if (wr_acc_hi) begin
            acc_nxt = {hwdata[7:0], acc_r[31:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= ACC_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Multiplier registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < MR_NUM; i++) begin
                mr_r[i] <= 32'h0000_0000;
            end
        end else if (commit) begin
            mr_r[w_r] <= mem_rsp_data;
        end else if (wr_is_mr) begin
            mr_r[wmr_off[3:2]] <= hwdata;
        end
    end

    // ------------------------------------------------------------------
    // Captured load operands
    // ------------------------------------------------------------------
    // sources sampled at issue.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m1_r    <= 16'h0000;
            m2_r    <= 16'h0000;
            w_r     <= 2'h0;
            idx_r   <= '0;
            vaddr_r <= 32'h0000_0000;
        end else if (accept && is_load) begin
            m1_r    <= m1;
            m2_r    <= m2;
            w_r     <= op_w;
            idx_r   <= op_gr_idx;
            vaddr_r <= vaddr_calc;
        end
    end

    // ------------------------------------------------------------------
    // General register write-back and completion
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gr_wr_en_r   <= 1'b0;
            gr_wr_idx_r  <= '0;
            gr_wr_data_r <= 32'h0000_0000;
            done_r       <= 1'b0;
        end else begin
            gr_wr_en_r <= (accept && is_multiply_low_word) || commit;
            done_r     <= ev_done;
            if (accept && is_multiply_low_word) begin
                gr_wr_idx_r  <= op_gr_idx;
                gr_wr_data_r <= multiply_low_word_low;
            end else if (commit) begin
                gr_wr_idx_r  <= idx_r;
                gr_wr_data_r <= vaddr_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Exceptions
    // ------------------------------------------------------------------
    // a fault only records its cause and address; the accumulator, multiplier
    // registers and base register are left alone because commit is low.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_valid_r  <= 1'b0;
            exc_cause_r  <= CAUSE_NONE;
            fault_addr_r <= 32'h0000_0000;
        end else begin
            exc_valid_r <= ev_fault || ev_misalign;
            if (ev_misalign) begin
                exc_cause_r  <= CAUSE_MISALIGN;
                fault_addr_r <= vaddr_calc;
            end else if (ev_fault) begin
                exc_cause_r  <= CAUSE_LOAD_FAULT;
                fault_addr_r <= vaddr_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = hrdata_r;
    assign irq           = |(sts_r & mask_r);
    assign op_ready      = (state_r == ST_IDLE);
    assign op_done       = done_r;
    assign gr_wr_en      = gr_wr_en_r;
    assign gr_wr_idx     = gr_wr_idx_r;
    assign gr_wr_data    = gr_wr_data_r;
    assign xlat_vaddr    = vaddr_eff;
    assign mem_req_valid = (state_r == ST_REQ) && !xlat_err;
    assign mem_req_addr  = phys_addr;
    assign exc_valid     = exc_valid_r;
    assign exc_cause     = exc_cause_r;
    assign exc_addr      = fault_addr_r;
    assign acc_value     = acc_r;

endmodule

// *** hdl/mac_load_pkg.sv ***
package mac_load_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_STATUS     = 8'h04;
    localparam logic [7:0] OFF_MASK       = 8'h08;
    localparam logic [7:0] OFF_FAULT_ADDR = 8'h0C;
    localparam logic [7:0] OFF_ACC_LO     = 8'h10;
    localparam logic [7:0] OFF_ACC_HI     = 8'h14;
    localparam logic [7:0] OFF_MR0        = 8'h18;
    localparam logic [7:0] OFF_MR_STEP    = 8'h04;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_TRAP_BIT   = 0;
    localparam int CTRL_XLAT_BIT   = 1;
    localparam int CTRL_W          = 2;
    localparam int EV_DONE_BIT     = 0;
    localparam int EV_FAULT_BIT    = 1;
    localparam int EV_MISALIGN_BIT = 2;
    localparam int EV_W            = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam logic [EV_W-1:0]   MASK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Datapath widths and constants
    // ------------------------------------------------------------------
    localparam int ACC_W  = 40;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int MR_NUM = 4;
    localparam logic [WORD_W-1:0] LOAD_STEP = 32'h0000_0004;
    localparam logic [ACC_W-1:0]  ACC_RESET = 40'h00_0000_0000;

    // ------------------------------------------------------------------
    // Operation codes from the decoder
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_MAC_LOAD_PREDEC = 3'h0;
    localparam logic [2:0] OP_MAC_LOAD_PREINC = 3'h1;
    localparam logic [2:0] OP_MULTIPLY_LOW    = 3'h2;
    localparam logic [2:0] OP_SUB_GG          = 3'h3;
    localparam logic [2:0] OP_SUB_GM          = 3'h4;
    localparam logic [2:0] OP_SUB_MG          = 3'h5;

    // Exception causes.
    localparam logic [1:0] CAUSE_NONE       = 2'h0;
    localparam logic [1:0] CAUSE_LOAD_FAULT = 2'h1;
    localparam logic [1:0] CAUSE_MISALIGN   = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_WAIT
    } state_e;

endpackage
